// file: logic/serial_defines.svh
// register offsets, field positions, reset values and counts of the serial status block
`ifndef SERIAL_DEFINES_SVH
`define SERIAL_DEFINES_SVH
`define SER_ADDR_W 12
`define SER_OFF_STATUS 12'h000
`define SER_OFF_MODE 12'h004
`define SER_OFF_TXDATA 12'h008
`define SER_OFF_RXDATA 12'h00c
`define SER_OFF_IRQ_STAT 12'h010
`define SER_OFF_IRQ_CLR 12'h014
`define SER_OFF_IRQ_EN 12'h018
`define ST_TX_ISEL1 15
`define ST_TX_INV 14
`define ST_TX_ISEL0 13
`define ST_TX_BRK 11
`define ST_TX_EN 10
`define ST_TXBF 9
`define ST_TX_SHIFTER_EMPTY 8
`define ST_RX_ISEL1 7
`define ST_RX_ISEL0 6
`define ST_ADDR_EN 5
`define ST_RX_IDLE 4
`define ST_PARITY_ERROR 3
`define ST_FRAMING_ERROR 2
`define ST_OVERRUN_ERROR 1
`define ST_RXDA 0
`define MD_BLK_EN 0
`define MD_IR_EN 1
`define MD_FMT_LO 2
`define MD_DIV_LO 16
`define IRQ_TX 0
`define IRQ_RX 1
`define IRQ_ERR 2
`define SER_DIV_RST 16'h0000
`define SER_Q_DEPTH 4
`define SER_PTR_W 2
`define SER_CNT_W 3
`define SER_OS_MID 4'h7
`define SER_OS_LAST 4'hf
`define SER_IR_PULSE 4'h3
`define SER_FMT_8N 2'h0
`define SER_FMT_8E 2'h1
`define SER_FMT_8O 2'h2
`define SER_FMT_9N 2'h3
`define SER_BITS_8 4'ha
`define SER_BITS_9 4'hb
`define SER_BITS_BRK 4'he
`define SER_BRK_FRAME 14'h2000
`endif

// file: logic/serial_pkg.sv
// types shared by the serial status block and its helpers
`include "serial_defines.svh"
package serial_pkg;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;
  typedef struct packed {
    logic parity_error;
    logic framing_error;
    logic [8:0] data;
  } rx_entry_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_state_t;
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;
  typedef struct packed {
    logic [1:0] tx_isel;
    logic tx_inv;
    logic tx_brk;
    logic tx_en;
    logic [1:0] rx_isel;
    logic addr_en;
    logic overrun_error;
    logic blk_en;
    logic ir_en;
    logic [1:0] fmt;
    logic [15:0] div;
    logic [`SER_Q_DEPTH-1:0][8:0] txq;
    logic [`SER_PTR_W-1:0] tx_wp;
    logic [`SER_PTR_W-1:0] tx_rp;
    logic [`SER_CNT_W-1:0] tx_cnt;
    logic tx_busy;
    logic [13:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx_os;
    logic tx_brk_act;
    logic tx_pin;
    logic tx_oe;
    rx_entry_t [`SER_Q_DEPTH-1:0] rxq;
    logic [`SER_PTR_W-1:0] rx_wp;
    logic [`SER_PTR_W-1:0] rx_rp;
    logic [`SER_CNT_W-1:0] rx_cnt;
    rx_state_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_bits;
    logic [9:0] rx_sh;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic [31:0] rdata;
    logic slverr;
  } serial_state_t;
endpackage

// file: logic/baud_tick.sv
// oversampling tick divider: one-cycle pulse every divisor+1 clocks
module baud_tick (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [15:0] divisor,
  output logic tick
);
  serial_pkg::tick_state_t st_r;
  serial_pkg::tick_state_t st_nxt;

  // counter restarts while disabled so the first tick is a full period away
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!enable)
      st_nxt.cnt = 16'h0000;
    else if (st_r.cnt >= divisor)
    begin
      st_nxt.cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick = st_r.tick;
endmodule

// file: logic/sync2.sv
// two-flop synchroniser for the receive pin
module sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  serial_pkg::sync_state_t st_r;

  // idle line is high, so both stages reset to one; s1 feeds only s2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= 2'h3;
    else
    begin
      st_r.s1 <= din;
      st_r.s2 <= st_r.s1;
    end
  end

  assign dout = st_r.s2;
endmodule

// file: logic/uart_status_rx_irq.sv
// serial transceiver with status/control register, receive buffer and interrupt logic
`include "serial_defines.svh"
module uart_status_rx_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SER_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic serial_tx_oe,
  output logic irq
);
  serial_pkg::serial_state_t st_r;
  serial_pkg::serial_state_t st_nxt;
  serial_pkg::rx_entry_t rx_top;
  serial_pkg::rx_entry_t rx_new;
  logic tick;
  logic rxs;
  logic setup;
  logic wr;
  logic rd;
  logic [`SER_ADDR_W-1:0] aoff;
  logic [15:0] status_rd;
  logic tx_push;
  logic tx_load;
  logic tx_done;
  logic rx_done;
  logic rx_push;
  logic rx_pop;
  logic overrun_ev;
  logic overrun_error_clear;
  logic tx_bit;
  logic [`SER_CNT_W-1:0] tx_cnt_after;
  logic [`SER_CNT_W-1:0] rx_cnt_push;
  logic [2:0] irq_ev;

  baud_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st_r.blk_en),
    .divisor(st_r.div),
    .tick(tick)
  );

  sync2 u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(serial_rx_pin),
    .dout(rxs)
  );

  // one transmit frame, lsb first, stop bits padded high
  function automatic logic [13:0] tx_frame(input logic [1:0] fmt, input logic [8:0] d);
    logic [13:0] f;
    f = {5'h1f, d[7:0], 1'b0};
    if (fmt == `SER_FMT_8E)
      f = {4'hf, ^d[7:0], d[7:0], 1'b0};
    else if (fmt == `SER_FMT_8O)
      f = {4'hf, ~^d[7:0], d[7:0], 1'b0};
    else if (fmt == `SER_FMT_9N)
      f = {4'hf, d, 1'b0};
    return f;
  endfunction

  // apb phase decode; address is word aligned
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & ~st_r.slverr;
  assign rd = psel & penable & ~pwrite & ~st_r.slverr;
  assign aoff = paddr;
  assign rx_top = st_r.rxq[st_r.rx_rp];

  // status register image
  always_comb
  begin
    status_rd = 16'h0000;
    status_rd[`ST_TX_ISEL1] = st_r.tx_isel[1];
    status_rd[`ST_TX_INV] = st_r.tx_inv;
    status_rd[`ST_TX_ISEL0] = st_r.tx_isel[0];
    status_rd[`ST_TX_BRK] = st_r.tx_brk;
    status_rd[`ST_TX_EN] = st_r.tx_en;
    status_rd[`ST_TXBF] = (st_r.tx_cnt == `SER_CNT_W'(`SER_Q_DEPTH));
    status_rd[`ST_TX_SHIFTER_EMPTY] = ~st_r.tx_busy & (st_r.tx_cnt == '0);
    status_rd[`ST_RX_ISEL1] = st_r.rx_isel[1];
    status_rd[`ST_RX_ISEL0] = st_r.rx_isel[0];
    status_rd[`ST_ADDR_EN] = st_r.addr_en;
    status_rd[`ST_RX_IDLE] = (st_r.rx_st == serial_pkg::RX_IDLE);
    // flags come from whatever entry is at the top, so a pop refreshes them
    status_rd[`ST_PARITY_ERROR] = (st_r.rx_cnt != '0) & rx_top.parity_error;
    status_rd[`ST_FRAMING_ERROR] = (st_r.rx_cnt != '0) & rx_top.framing_error;
    status_rd[`ST_OVERRUN_ERROR] = st_r.overrun_error;
    status_rd[`ST_RXDA] = (st_r.rx_cnt != '0);
  end

  // received character fields, extracted from the shifter at the stop bit
  always_comb
  begin
    rx_new.framing_error = ~rxs;
    rx_new.parity_error = 1'b0;
    rx_new.data = {1'b0, st_r.rx_sh[9:2]};
    if (st_r.fmt == `SER_FMT_9N)
      rx_new.data = st_r.rx_sh[9:1];
    else if (st_r.fmt == `SER_FMT_8E)
    begin
      rx_new.data = {1'b0, st_r.rx_sh[8:1]};
      rx_new.parity_error = ^st_r.rx_sh[9:1];
    end
    else if (st_r.fmt == `SER_FMT_8O)
    begin
      rx_new.data = {1'b0, st_r.rx_sh[8:1]};
      rx_new.parity_error = ~^st_r.rx_sh[9:1];
    end
  end

  // event terms shared by the next-state logic
  always_comb
  begin
    tx_push = wr & (aoff == `SER_OFF_TXDATA) & st_r.tx_en
      & (st_r.tx_cnt != `SER_CNT_W'(`SER_Q_DEPTH));
    tx_load = st_r.blk_en & st_r.tx_en & ~st_r.tx_busy & (st_r.tx_cnt != '0);
    tx_done = st_r.tx_busy & tick & (st_r.tx_os == `SER_OS_LAST) & (st_r.tx_bits == 4'h1);
    tx_cnt_after = st_r.tx_cnt + `SER_CNT_W'(tx_push) - `SER_CNT_W'(tx_load);
    rx_done = tick & (st_r.rx_st == serial_pkg::RX_STOP) & (st_r.rx_os == `SER_OS_LAST);
    // in 9-bit mode with address detect, data characters never reach the buffer
    rx_push = rx_done & ~st_r.overrun_error & (st_r.rx_cnt != `SER_CNT_W'(`SER_Q_DEPTH))
      & ~(st_r.addr_en & (st_r.fmt == `SER_FMT_9N) & ~rx_new.data[8]);
    overrun_ev = rx_done & ~st_r.overrun_error & (st_r.rx_cnt == `SER_CNT_W'(`SER_Q_DEPTH));
    rx_pop = rd & (aoff == `SER_OFF_RXDATA) & (st_r.rx_cnt != '0);
    rx_cnt_push = st_r.rx_cnt + `SER_CNT_W'(1);
    overrun_error_clear = wr & (aoff == `SER_OFF_STATUS) & st_r.overrun_error & ~pwdata[`ST_OVERRUN_ERROR];
    irq_ev = 3'h0;
    case (st_r.tx_isel)
      2'h0: irq_ev[`IRQ_TX] = tx_load;
      2'h1: irq_ev[`IRQ_TX] = tx_done & (st_r.tx_cnt == '0);
      2'h2: irq_ev[`IRQ_TX] = tx_load & (tx_cnt_after == '0);
      default: irq_ev[`IRQ_TX] = 1'b0;
    endcase
    case (st_r.rx_isel)
      2'h3: irq_ev[`IRQ_RX] = rx_push & (rx_cnt_push == `SER_CNT_W'(4));
      2'h2: irq_ev[`IRQ_RX] = rx_push & (rx_cnt_push == `SER_CNT_W'(3));
      default: irq_ev[`IRQ_RX] = rx_push;
    endcase
    irq_ev[`IRQ_ERR] = overrun_ev | (rx_push & (rx_new.parity_error | rx_new.framing_error));
  end

  // transmit line before pin encoding
  assign tx_bit = st_r.tx_busy ? st_r.tx_sh[0] : 1'b1;

  // next state
  always_comb
  begin
    st_nxt = st_r;
    // register writes
    if (wr & (aoff == `SER_OFF_STATUS))
    begin
      st_nxt.tx_isel = {pwdata[`ST_TX_ISEL1], pwdata[`ST_TX_ISEL0]};
      st_nxt.tx_inv = pwdata[`ST_TX_INV];
      st_nxt.tx_brk = pwdata[`ST_TX_BRK];
      st_nxt.tx_en = pwdata[`ST_TX_EN];
      st_nxt.rx_isel = {pwdata[`ST_RX_ISEL1], pwdata[`ST_RX_ISEL0]};
      st_nxt.addr_en = pwdata[`ST_ADDR_EN];
    end
    if (wr & (aoff == `SER_OFF_MODE))
    begin
      st_nxt.blk_en = pwdata[`MD_BLK_EN];
      st_nxt.ir_en = pwdata[`MD_IR_EN];
      st_nxt.fmt = pwdata[`MD_FMT_LO +: 2];
      st_nxt.div = pwdata[`MD_DIV_LO +: 16];
    end
    if (wr & (aoff == `SER_OFF_IRQ_EN))
      st_nxt.irq_en = pwdata[2:0];
    // sticky interrupt bits: a new event wins over a clear in the same cycle
    if (wr & (aoff == `SER_OFF_IRQ_CLR))
      st_nxt.irq_st = st_r.irq_st & ~pwdata[2:0];
    st_nxt.irq_st = st_nxt.irq_st | irq_ev;

    // transmit buffer fill
    if (tx_push)
    begin
      st_nxt.txq[st_r.tx_wp] = pwdata[8:0];
      st_nxt.tx_wp = st_r.tx_wp + `SER_PTR_W'(1);
    end
    st_nxt.tx_cnt = tx_cnt_after;
    // load the shifter; a pending break replaces the character's frame
    if (tx_load)
    begin
      st_nxt.tx_rp = st_r.tx_rp + `SER_PTR_W'(1);
      st_nxt.tx_busy = 1'b1;
      st_nxt.tx_os = 4'h0;
      st_nxt.tx_brk_act = st_r.tx_brk;
      if (st_r.tx_brk)
      begin
        st_nxt.tx_sh = `SER_BRK_FRAME;
        st_nxt.tx_bits = `SER_BITS_BRK;
      end
      else
      begin
        st_nxt.tx_sh = tx_frame(st_r.fmt, st_r.txq[st_r.tx_rp]);
        st_nxt.tx_bits = (st_r.fmt == `SER_FMT_8N) ? `SER_BITS_8 : `SER_BITS_9;
      end
    end
    // shift one bit per sixteen ticks
    if (st_r.tx_busy & tick)
    begin
      st_nxt.tx_os = st_r.tx_os + 4'h1;
      if (st_r.tx_os == `SER_OS_LAST)
      begin
        st_nxt.tx_sh = {1'b1, st_r.tx_sh[13:1]};
        st_nxt.tx_bits = st_r.tx_bits - 4'h1;
      end
    end
    if (tx_done)
    begin
      st_nxt.tx_busy = 1'b0;
      if (st_r.tx_brk_act)
        st_nxt.tx_brk = 1'b0;
      st_nxt.tx_brk_act = 1'b0;
    end
    // transmitter off: drop queued and in-flight characters
    if (~st_nxt.tx_en | ~st_nxt.blk_en)
    begin
      st_nxt.tx_busy = 1'b0;
      st_nxt.tx_brk_act = 1'b0;
      st_nxt.tx_cnt = '0;
      st_nxt.tx_wp = '0;
      st_nxt.tx_rp = '0;
    end
    // pin drive: inversion and pulse encoding only in infrared mode
    st_nxt.tx_oe = st_r.blk_en & st_r.tx_en;
    if (st_r.ir_en)
      st_nxt.tx_pin = (~tx_bit & st_r.tx_busy & (st_r.tx_os < `SER_IR_PULSE)) ^ st_r.tx_inv;
    else
      st_nxt.tx_pin = tx_bit;

    // receiver, sampling mid-bit on the oversampling tick
    if (tick)
    begin
      case (st_r.rx_st)
        serial_pkg::RX_IDLE:
        begin
          st_nxt.rx_os = 4'h0;
          if (~rxs)
            st_nxt.rx_st = serial_pkg::RX_START;
        end
        serial_pkg::RX_START:
        begin
          st_nxt.rx_os = st_r.rx_os + 4'h1;
          // a start bit gone by mid-bit was a glitch
          if (st_r.rx_os == `SER_OS_MID)
          begin
            st_nxt.rx_os = 4'h0;
            st_nxt.rx_st = rxs ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
            st_nxt.rx_bits = (st_r.fmt == `SER_FMT_8N) ? 4'h8 : 4'h9;
          end
        end
        serial_pkg::RX_DATA:
        begin
          st_nxt.rx_os = st_r.rx_os + 4'h1;
          if (st_r.rx_os == `SER_OS_LAST)
          begin
            st_nxt.rx_sh = {rxs, st_r.rx_sh[9:1]};
            st_nxt.rx_bits = st_r.rx_bits - 4'h1;
            if (st_r.rx_bits == 4'h1)
              st_nxt.rx_st = serial_pkg::RX_STOP;
          end
        end
        serial_pkg::RX_STOP:
        begin
          st_nxt.rx_os = st_r.rx_os + 4'h1;
          if (st_r.rx_os == `SER_OS_LAST)
            st_nxt.rx_st = serial_pkg::RX_IDLE;
        end
        default: st_nxt.rx_st = serial_pkg::RX_IDLE;
      endcase
    end
    if (~st_r.blk_en)
      st_nxt.rx_st = serial_pkg::RX_IDLE;

    // receive buffer: push at stop bit, pop on data read
    if (rx_push)
    begin
      st_nxt.rxq[st_r.rx_wp] = rx_new;
      st_nxt.rx_wp = st_r.rx_wp + `SER_PTR_W'(1);
    end
    if (rx_pop)
      st_nxt.rx_rp = st_r.rx_rp + `SER_PTR_W'(1);
    st_nxt.rx_cnt = st_r.rx_cnt + `SER_CNT_W'(rx_push) - `SER_CNT_W'(rx_pop);
    // clearing overrun empties buffer and shifter; a fresh overrun still wins
    if (overrun_error_clear)
    begin
      st_nxt.rx_cnt = '0;
      st_nxt.rx_wp = '0;
      st_nxt.rx_rp = '0;
      st_nxt.rx_st = serial_pkg::RX_IDLE;
      st_nxt.overrun_error = 1'b0;
    end
    if (overrun_ev)
      st_nxt.overrun_error = 1'b1;

    // read data captured in setup so prdata comes from a flop with no wait state
    if (setup)
    begin
      st_nxt.slverr = 1'b0;
      st_nxt.rdata = 32'h0000_0000;
      if (paddr == `SER_OFF_STATUS)
        st_nxt.rdata = {16'h0000, status_rd};
      else if (paddr == `SER_OFF_MODE)
        st_nxt.rdata = {st_r.div, 12'h000, st_r.fmt, st_r.ir_en, st_r.blk_en};
      else if (paddr == `SER_OFF_TXDATA)
        st_nxt.rdata = 32'h0000_0000;
      else if (paddr == `SER_OFF_RXDATA)
        st_nxt.rdata = {23'h000000, rx_top.data & {9{st_r.rx_cnt != '0}}};
      else if (paddr == `SER_OFF_IRQ_STAT)
        st_nxt.rdata = {29'h00000000, st_r.irq_st};
      else if (paddr == `SER_OFF_IRQ_CLR)
        st_nxt.rdata = 32'h0000_0000;
      else if (paddr == `SER_OFF_IRQ_EN)
        st_nxt.rdata = {29'h00000000, st_r.irq_en};
      else
        st_nxt.slverr = 1'b1;
    end
  end

  // single state register; receiver starts idle and the pin idles high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.rx_st <= serial_pkg::RX_IDLE;
      st_r.div <= `SER_DIV_RST;
      st_r.tx_pin <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // outputs
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & st_r.slverr;
  assign serial_tx_pin = st_r.tx_pin;
  assign serial_tx_oe = st_r.tx_oe;
  assign irq = |(st_r.irq_st & st_r.irq_en);
endmodule

// file: sim/serial_status_assertions.sv
// port-level checks on the serial status block, attached by bind
`include "serial_defines.svh"
module serial_status_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SER_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic serial_tx_oe,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_acc;
  logic [2:0] ien_r;
  logic [1:0] en_r;
  logic seen_r;
  logic flushed_r;
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  // shadows of written fields; mapped writes always land at the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ien_r <= 3'h0;
      en_r <= 2'h0;
      seen_r <= 1'b0;
      flushed_r <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == `SER_OFF_IRQ_EN)
        ien_r <= pwdata[2:0];
      if (wr_acc && paddr == `SER_OFF_MODE)
        en_r[0] <= pwdata[`MD_BLK_EN];
      if (wr_acc && paddr == `SER_OFF_STATUS)
        en_r[1] <= pwdata[`ST_TX_EN];
      // overrun only sets by itself, so a seen flag stays valid until a status write
      if (acc && !pwrite && paddr == `SER_OFF_STATUS && prdata[`ST_OVERRUN_ERROR])
        seen_r <= 1'b1;
      else if (wr_acc && paddr == `SER_OFF_STATUS)
        seen_r <= 1'b0;
      // flushed holds until new line activity could refill the buffer
      if (wr_acc && paddr == `SER_OFF_STATUS && seen_r && !pwdata[`ST_OVERRUN_ERROR])
        flushed_r <= 1'b1;
      else if (!serial_rx_pin)
        flushed_r <= 1'b0;
    end
  end
  sequence s_read(logic [`SER_ADDR_W-1:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  AST_PREADY: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  AST_SLVERR: assert property (acc && paddr > `SER_OFF_IRQ_EN |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_TX_FLAGS: assert property (s_read(`SER_OFF_STATUS) |-> !(prdata[9] && prdata[8]))
    else $error("buffer full and shifter empty at once");
  AST_ERR_EMPTY: assert property (s_read(`SER_OFF_STATUS) ##0 !prdata[0] |-> prdata[3:2] == 2'h0)
    else $error("error flags set with empty buffer");
  AST_OE_FOLLOW: assert property (wr_acc && (paddr == `SER_OFF_STATUS || paddr == `SER_OFF_MODE)
    |-> ##2 serial_tx_oe == (en_r == 2'h3))
    else $error("pin enable does not follow enables");
  AST_IRQ_MASK: assert property (ien_r == 3'h0 |-> !irq)
    else $error("interrupt while all masked");
  AST_IRQ_STAT: assert property (s_read(`SER_OFF_IRQ_STAT) ##0 (prdata[2:0] & ien_r) != 3'h0
    |-> irq)
    else $error("enabled status bit without interrupt");
  AST_OVERRUN_ERROR_FLUSH: assert property (s_read(`SER_OFF_STATUS) ##0 flushed_r |-> prdata[1:0] == 2'h0)
    else $error("overrun clear did not empty the buffer");
endmodule

// file: sim/serial_remote.sv
// remote serial transmitter driving the receive line of the block
module serial_remote #(
  parameter int BIT_CYCLES = 16
) (
  output logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_tick;
  initial line = 1'b1;
  // timing comes from the bench clock so frames stay aligned to divisor 0
  assign clk_tick = tb_top.pclk;
  // gap sets prompt or slow spacing; the line idles high as with a pull-up
  task automatic send(input logic [11:0] frame, input int n, input int gap);
    repeat (gap) @(posedge clk_tick);
    line <= 1'b0;
    repeat (BIT_CYCLES) @(posedge clk_tick);
    for (int i = 0; i < n; i++)
    begin
      line <= frame[i];
      repeat (BIT_CYCLES) @(posedge clk_tick);
    end
    line <= 1'b1;
  endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench for the serial status block
`include "serial_defines.svh"
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`SER_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_line;
  logic serial_tx_pin;
  logic serial_tx_oe;
  logic irq;
  logic [31:0] rd;
  logic err;
  logic [7:0] ch;
  int failures;
  int checks_done;
  int thr[4] = '{1, 1, 3, 4};
  uart_status_rx_irq u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(rx_line), .serial_tx_pin(serial_tx_pin), .serial_tx_oe(serial_tx_oe),
    .irq(irq)
  );
  serial_remote u_remote (
    .line(rx_line)
  );
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // one transfer; the answer is taken at the rising edge where pready is high
  // an idle edge follows so the next call never re-raises psel in the same step
  task automatic xfer(input logic wr, input logic [`SER_ADDR_W-1:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [`SER_ADDR_W-1:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask
  task automatic check_rd(input logic [`SER_ADDR_W-1:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    `CHK(rd & m, exp)
  endtask
  task automatic wait_irq(input int limit);
    for (int i = 0; i < limit && irq !== 1'b1; i++)
      @(posedge pclk);
    `CHK(irq, 1'b1)
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog sized well above the roughly 5600 cycles the tests need
  initial
  begin
    repeat (30000) @(posedge pclk);
    failures++;
    $display("watchdog expired");
    complete_run();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_rd(`SER_OFF_STATUS, 32'hffff_ffff, 32'h0110);
    check_rd(12'h01c, 32'hffff_ffff, 32'h0);
    `CHK(err, 1'b1)
    $display("reset test done");
    // five characters: one in the shifter, four fill the buffer
    wr(`SER_OFF_MODE, 32'h1);
    wr(`SER_OFF_IRQ_EN, 32'h1);
    wr(`SER_OFF_STATUS, 32'h2400);
    for (int i = 0; i < 5; i++)
      wr(`SER_OFF_TXDATA, 32'h41 + 32'(i));
    check_rd(`SER_OFF_STATUS, 32'h0300, 32'h0200);
    `CHK(irq, 1'b0)
    wait_irq(1500);
    check_rd(`SER_OFF_STATUS, 32'h0300, 32'h0100);
    wr(`SER_OFF_STATUS, 32'h8400);
    wr(`SER_OFF_IRQ_CLR, 32'h7);
    wr(`SER_OFF_TXDATA, 32'h55);
    wait_irq(20);
    check_rd(`SER_OFF_STATUS, 32'h0100, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(`SER_OFF_TXDATA, 32'h60);
    wr(`SER_OFF_STATUS, 32'h0);
    check_rd(`SER_OFF_STATUS, 32'h0200, 32'h0);
    `CHK(serial_tx_oe, 1'b0)
    // break on the next load; select 00 flags the load itself
    wr(`SER_OFF_IRQ_CLR, 32'h7);
    wr(`SER_OFF_STATUS, 32'h0c00);
    wr(`SER_OFF_TXDATA, 32'h0);
    wait_irq(20);
    repeat (100) @(posedge pclk);
    `CHK(serial_tx_pin, 1'b0)
    check_rd(`SER_OFF_STATUS, 32'h0900, 32'h0800);
    repeat (150) @(posedge pclk);
    check_rd(`SER_OFF_STATUS, 32'h0900, 32'h0100);
    // inversion is ignored until the infrared encoder is on; pin settles one edge later
    wr(`SER_OFF_STATUS, 32'h4000);
    @(posedge pclk);
    `CHK(serial_tx_pin, 1'b1)
    wr(`SER_OFF_MODE, 32'h3);
    wr(`SER_OFF_STATUS, 32'h0);
    @(posedge pclk);
    `CHK(serial_tx_pin, 1'b0)
    wr(`SER_OFF_MODE, 32'h1);
    $display("transmit test done");
    // each threshold code, four characters per code
    wr(`SER_OFF_IRQ_EN, 32'h2);
    for (int m = 0; m < 4; m++)
    begin
      wr(`SER_OFF_STATUS, 32'(m << 6));
      wr(`SER_OFF_IRQ_CLR, 32'h7);
      for (int k = 1; k <= 4; k++)
      begin
        ch = 8'h30 + 8'(k);
        u_remote.send({4'b0001, ch}, 9, 2);
        `CHK(irq, k >= thr[m])
      end
      for (int k = 1; k <= 4; k++)
        check_rd(`SER_OFF_RXDATA, 32'h1ff, 32'h30 + 32'(k));
      check_rd(`SER_OFF_STATUS, 32'h1, 32'h0);
    end
    $display("threshold test done");
    // even parity: a bad parity bit, then a low stop bit
    wr(`SER_OFF_MODE, 32'h5);
    fork
      u_remote.send({4'b0010, 8'h01}, 10, 40);
      begin
        repeat (120) @(posedge pclk);
        check_rd(`SER_OFF_STATUS, 32'h10, 32'h0);
      end
    join
    u_remote.send({4'b0000, 8'h03}, 10, 2);
    check_rd(`SER_OFF_STATUS, 32'hd, 32'h9);
    check_rd(`SER_OFF_RXDATA, 32'hff, 32'h01);
    check_rd(`SER_OFF_STATUS, 32'hd, 32'h5);
    check_rd(`SER_OFF_RXDATA, 32'hff, 32'h03);
    check_rd(`SER_OFF_STATUS, 32'hd, 32'h0);
    // odd parity: a correct parity bit leaves the flag clear
    wr(`SER_OFF_MODE, 32'h9);
    u_remote.send({4'b0010, 8'h01}, 10, 2);
    check_rd(`SER_OFF_STATUS, 32'hd, 32'h1);
    check_rd(`SER_OFF_RXDATA, 32'hff, 32'h01);
    $display("error flag test done");
    // nine-bit mode with address detect: plain data is dropped
    wr(`SER_OFF_MODE, 32'hd);
    wr(`SER_OFF_STATUS, 32'h20);
    u_remote.send({3'b001, 9'h0a5}, 10, 2);
    u_remote.send({3'b001, 9'h1a5}, 10, 2);
    check_rd(`SER_OFF_RXDATA, 32'h1ff, 32'h1a5);
    check_rd(`SER_OFF_STATUS, 32'h1, 32'h0);
    // five characters into four places, then recovery
    wr(`SER_OFF_MODE, 32'h1);
    wr(`SER_OFF_STATUS, 32'h0);
    wr(`SER_OFF_IRQ_EN, 32'h6);
    for (int i = 0; i < 5; i++)
      u_remote.send({4'b0001, 8'h50}, 9, 1);
    check_rd(`SER_OFF_STATUS, 32'h3, 32'h3);
    check_rd(`SER_OFF_IRQ_STAT, 32'h4, 32'h4);
    wr(`SER_OFF_STATUS, 32'h0);
    check_rd(`SER_OFF_STATUS, 32'h3, 32'h0);
    $display("overrun test done");
    complete_run();
  end
endmodule
bind uart_status_rx_irq serial_status_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
  .serial_tx_oe(serial_tx_oe), .irq(irq)
);
